/* verilog/gpc_command_ctrl.sv */
// Graphics port command register with request gating and rate select.
// Assumes request pins are asynchronous to CLK_I and that the register
// port master follows the one-cycle strobe protocol on CLK_I.
//
// How it works
// - Command bit 9 turns the sideband request path on at one, off at zero.
// - While port enable bit 8 is zero all requests, sync too, are ignored.
// - Requests taken while the port was enabled are completed after disable.
// - A sideband command underway at single rate issues even if enable falls.
// - With port enable set, pipe requests are taken until the queue is full, sideband only with bit 9.
// - Bit 5 reads as zero since no address above 4 GB is accepted.
// - Rate bit 0 selects single, bit 1 double and bit 2 quadruple rate.
// - The chosen rate bit matches the one set in the graphics master.
// - With the quad rate mask set, rate bit 2 ignores writes but reads back.
// - The chosen rate drives both the main bus and the sideband bus.
// - The command register is 32 bits, read/write, all zero after reset.
// - Bit 0 of the auxiliary control register is the quad rate mask.

`timescale 1ns/100ps

module gpc_command_ctrl
#(
    parameter int QUEUE_DEPTH = gpc_pkg::QUEUE_DEPTH_DEF
)
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [gpc_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic [gpc_pkg::DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [gpc_pkg::DATA_W-1:0] REG_RDATA_O,
    input wire logic PIPE_REQ_N_I,
    input wire logic SBA_CMD_I,
    input wire logic SYNC_REQ_I,
    input wire logic SERVICE_DONE_I,
    output logic PIPE_ACCEPT_O,
    output logic SBA_ISSUE_O,
    output logic SYNC_ACCEPT_O,
    output logic SERVICE_PEND_O,
    output logic QUEUE_FULL_O,
    output logic PORT_EN_O,
    output logic SBA_EN_O,
    output logic POSTED_WRITE_EN_O,
    output logic [2:0] AD_RATE_O,
    output logic [2:0] SBA_RATE_O
);

    localparam int CNT_W = $clog2(QUEUE_DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(QUEUE_DEPTH);

    // Refuse a queue that cannot hold a single request
    generate
        if (QUEUE_DEPTH < 1)
        begin : g_bad_depth
            $error("QUEUE_DEPTH must be at least one");
        end
    endgenerate

    // Register state
    gpc_pkg::gpc_cmd_t cmd_q;
    gpc_pkg::gpc_cmd_t cmd_d;
    logic quad_rate_mask_q;
    logic [gpc_pkg::DATA_W-1:0] rdata_q;
    logic [gpc_pkg::DATA_W-1:0] rdata_d;

    // Pin synchronisers and edge history
    gpc_pkg::gpc_pins_t pins_raw;
    gpc_pkg::gpc_pins_t sync1_q;
    gpc_pkg::gpc_pins_t sync2_q;
    gpc_pkg::gpc_pins_t prev_q;

    // Request tracking
    gpc_pkg::gpc_sb_state_t sb_q;
    gpc_pkg::gpc_sb_state_t sb_d;
    logic [CNT_W-1:0] pend_q;
    logic [CNT_W-1:0] pend_d;
    logic pipe_acc_q;
    logic sba_iss_q;
    logic sync_acc_q;

    // Decode wires
    wire cmd_sel = (REG_ADDR_I == gpc_pkg::CMD_OFFSET);
    wire aux_sel = (REG_ADDR_I == gpc_pkg::AUX_OFFSET);
    wire cmd_wr = REG_WR_I && cmd_sel;
    wire aux_wr = REG_WR_I && aux_sel;

    // Incoming write image of the command register
    gpc_pkg::gpc_cmd_t wr_img;
    assign wr_img = gpc_pkg::gpc_cmd_t'(REG_WDATA_I);

    // Rate bit 2 keeps its value while the quad rate mask is set
    wire rate_quad_next = quad_rate_mask_q
                        ? cmd_q.rate[gpc_pkg::RATE_QUAD_BIT]
                        : wr_img.rate[gpc_pkg::RATE_QUAD_BIT];

    // Next command value: only defined fields take write data
    always_comb
    begin
        cmd_d = cmd_q;
        if (cmd_wr)
        begin
            cmd_d = '0;
            cmd_d.sba_en = wr_img.sba_en;
            cmd_d.port_request_enable = wr_img.port_request_enable;
            cmd_d.posted_write_accel_enable = wr_img.posted_write_accel_enable;
            cmd_d.high_address_support = 1'b0;
            cmd_d.rate = {rate_quad_next, wr_img.rate[1:0]};
        end
    end

    // Read mux: command, auxiliary control, else zero
    wire [gpc_pkg::DATA_W-1:0] aux_rd =
        {{(gpc_pkg::DATA_W-1){1'b0}}, quad_rate_mask_q};
    always_comb
    begin
        rdata_d = gpc_pkg::UNMAPPED_READ;
        if (REG_RD_I && cmd_sel)
        begin
            rdata_d = cmd_q;
        end
        else if (REG_RD_I && aux_sel)
        begin
            rdata_d = aux_rd;
        end
    end

    // Register bank
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            cmd_q <= gpc_pkg::gpc_cmd_t'(gpc_pkg::CMD_RESET);
            quad_rate_mask_q <= gpc_pkg::AUX_RESET[gpc_pkg::AUX_QUAD_MASK_BIT];
            rdata_q <= gpc_pkg::UNMAPPED_READ;
        end
        else
        begin
            cmd_q <= cmd_d;
            rdata_q <= rdata_d;
            if (aux_wr)
            begin
                quad_rate_mask_q <= REG_WDATA_I[gpc_pkg::AUX_QUAD_MASK_BIT];
            end
        end
    end

    // Pipe request pin is active low; fold polarity before the synchroniser
    assign pins_raw = '{pipe_req: ~PIPE_REQ_N_I,
                        sba_cmd: SBA_CMD_I,
                        sync_req: SYNC_REQ_I};

    // Two-stage synchronisers, then a history stage for edge detection
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Edge events on synchronised pins
    wire pipe_rise = sync2_q.pipe_req && !prev_q.pipe_req;
    wire sync_rise = sync2_q.sync_req && !prev_q.sync_req;
    wire sba_rise = sync2_q.sba_cmd && !prev_q.sba_cmd;
    wire sba_fall = !sync2_q.sba_cmd && prev_q.sba_cmd;

    // Gating by the enable bits
    wire port_on = cmd_q.port_request_enable;
    wire sba_path_on = port_on && cmd_q.sba_en;
    wire queue_full = (pend_q == CNT_MAX);
    wire pipe_take = pipe_rise && port_on && !queue_full;
    wire sync_take = sync_rise && port_on;
    wire serv_done = SERVICE_DONE_I && (pend_q != CNT_ZERO);

    // Sideband command tracking: fate is settled when delivery starts
    always_comb
    begin
        sb_d = sb_q;
        unique case (sb_q)
            gpc_pkg::SB_IDLE:
            begin
                if (sba_rise && sba_path_on)
                begin
                    sb_d = gpc_pkg::SB_TAKE;
                end
                else if (sba_rise)
                begin
                    sb_d = gpc_pkg::SB_DROP;
                end
            end
            gpc_pkg::SB_TAKE:
            begin
                // Enable dropping here does not abort the command
                if (sba_fall)
                begin
                    sb_d = gpc_pkg::SB_IDLE;
                end
            end
            gpc_pkg::SB_DROP:
            begin
                if (sba_fall)
                begin
                    sb_d = gpc_pkg::SB_IDLE;
                end
            end
            default:
            begin
                sb_d = gpc_pkg::SB_IDLE;
            end
        endcase
    end

    // Issue a taken sideband command at the end of its delivery
    wire sba_issue = (sb_q == gpc_pkg::SB_TAKE) && sba_fall;

    // Outstanding pipe request count, held regardless of enable
    always_comb
    begin
        pend_d = pend_q;
        if (pipe_take && !serv_done)
        begin
            pend_d = pend_q + CNT_ONE;
        end
        else if (!pipe_take && serv_done)
        begin
            pend_d = pend_q - CNT_ONE;
        end
    end

    // Request tracking registers and event pulses
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            sb_q <= gpc_pkg::SB_IDLE;
            pend_q <= CNT_ZERO;
            pipe_acc_q <= 1'b0;
            sba_iss_q <= 1'b0;
            sync_acc_q <= 1'b0;
        end
        else
        begin
            sb_q <= sb_d;
            pend_q <= pend_d;
            pipe_acc_q <= pipe_take;
            sba_iss_q <= sba_issue;
            sync_acc_q <= sync_take;
        end
    end

    // Effective rate: masked quad bit has no functional effect
    wire [2:0] quad_gate = quad_rate_mask_q
                         ? (gpc_pkg::RATE_2X | gpc_pkg::RATE_1X)
                         : (gpc_pkg::RATE_4X | gpc_pkg::RATE_2X
                            | gpc_pkg::RATE_1X);
    wire [2:0] rate_eff = cmd_q.rate & quad_gate;

    // Outputs
    assign REG_RDATA_O = rdata_q;
    assign PIPE_ACCEPT_O = pipe_acc_q;
    assign SBA_ISSUE_O = sba_iss_q;
    assign SYNC_ACCEPT_O = sync_acc_q;
    assign SERVICE_PEND_O = (pend_q != CNT_ZERO);
    assign QUEUE_FULL_O = queue_full;
    assign PORT_EN_O = cmd_q.port_request_enable;
    assign SBA_EN_O = cmd_q.sba_en;
    assign POSTED_WRITE_EN_O = cmd_q.posted_write_accel_enable;
    assign AD_RATE_O = rate_eff;
    assign SBA_RATE_O = rate_eff;

endmodule : gpc_command_ctrl

/* verilog/gpc_pkg.sv */
// Package for the graphics port command register block.
// Assumes a single 40 MHz core clock and a plain register port.
package gpc_pkg;

    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] CMD_OFFSET = 8'hA8;
    localparam logic [7:0] AUX_OFFSET = 8'hB0;

    // Reset values
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    localparam logic [31:0] AUX_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // Field positions in the auxiliary control register
    localparam int AUX_QUAD_MASK_BIT = 0;

    // Rate field quad bit position, one-hot rate codes and the all-zero no-rate code
    localparam int RATE_QUAD_BIT = 2;
    localparam logic [2:0] RATE_1X = 3'h1;
    localparam logic [2:0] RATE_2X = 3'h2;
    localparam logic [2:0] RATE_4X = 3'h4;
    localparam logic [2:0] RATE_NONE = 3'h0;

    // Default number of outstanding queued requests
    localparam int QUEUE_DEPTH_DEF = 32;

    // Command register layout, most significant field first
    typedef struct packed {
        logic [21:0] rsvd_hi;
        logic sba_en;
        logic port_request_enable;
        logic [1:0] rsvd_mid;
        logic high_address_support;
        logic posted_write_accel_enable;
        logic rsvd_lo;
        logic [2:0] rate;
    } gpc_cmd_t;

    // Request pins after polarity correction
    typedef struct packed {
        logic pipe_req;
        logic sba_cmd;
        logic sync_req;
    } gpc_pins_t;

    // Sideband command tracking states, one-hot
    typedef enum logic [2:0] {
        SB_IDLE = 3'b001,
        SB_TAKE = 3'b010,
        SB_DROP = 3'b100
    } gpc_sb_state_t;

endpackage : gpc_pkg

/* tb/gpc_props.sv */
// Checker for the graphics port command register ports.
// Assumes it is bound to gpc_command_ctrl on one 40 MHz clock.
`timescale 1ns/100ps
module gpc_props
#(
    parameter int QUEUE_DEPTH = 2
)
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [gpc_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic [gpc_pkg::DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [gpc_pkg::DATA_W-1:0] REG_RDATA_O,
    input wire logic SERVICE_DONE_I,
    input wire logic PIPE_ACCEPT_O,
    input wire logic SBA_ISSUE_O,
    input wire logic SYNC_ACCEPT_O,
    input wire logic SERVICE_PEND_O,
    input wire logic PORT_EN_O,
    input wire logic SBA_EN_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // Command register accesses
    wire cmd_wr = REG_WR_I && REG_ADDR_I == gpc_pkg::CMD_OFFSET;
    wire cmd_rd = REG_RD_I && REG_ADDR_I == gpc_pkg::CMD_OFFSET;
    property p_en_wr;
        cmd_wr |=> {SBA_EN_O, PORT_EN_O} == $past(REG_WDATA_I[9:8]);
    endproperty
    a_en_wr: assert property (p_en_wr)
        else $error("enable bits not taken from write");
    property p_rd_en;
        cmd_rd |=> REG_RDATA_O[9:8] == {SBA_EN_O, PORT_EN_O};
    endproperty
    a_rd_en: assert property (p_rd_en)
        else $error("enable bits read back wrong");
    property p_rsvd;
        cmd_rd |=> (REG_RDATA_O & 32'hFFFF_FCE8) == '0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("fixed zero bits read as one");
    property p_rd_idle;
        REG_RDATA_O != '0 |-> $past(REG_RD_I);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_pipe_off;
        !PORT_EN_O [*2] |=> !PIPE_ACCEPT_O;
    endproperty
    a_pipe_off: assert property (p_pipe_off)
        else $error("pipe request taken while disabled");
    property p_sync_off;
        !PORT_EN_O [*2] |=> !SYNC_ACCEPT_O;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("sync taken while disabled");
    property p_pend_fall;
        $fell(SERVICE_PEND_O) |-> $past(SERVICE_DONE_I);
    endproperty
    a_pend_fall: assert property (p_pend_fall)
        else $error("pending work dropped without completion");
    property p_pipe_pend;
        PIPE_ACCEPT_O |-> SERVICE_PEND_O;
    endproperty
    a_pipe_pend: assert property (p_pipe_pend)
        else $error("accepted request not pending");
    // Main traffic seen
    c_pipe: cover property (PIPE_ACCEPT_O);
    c_sba: cover property (SBA_ISSUE_O);
    c_sync: cover property (SYNC_ACCEPT_O);
endmodule : gpc_props

bind gpc_command_ctrl gpc_props #(.QUEUE_DEPTH(QUEUE_DEPTH)) i_props (
    .CLK_I, .SYS_RST_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
    .REG_RDATA_O, .SERVICE_DONE_I, .PIPE_ACCEPT_O, .SBA_ISSUE_O,
    .SYNC_ACCEPT_O, .SERVICE_PEND_O, .PORT_EN_O, .SBA_EN_O
);

/* tb/gpc_master_model.sv */
// Graphics master model driving the request pins.
// Assumes one bench process calls req at a time.
`timescale 1ns/100ps
module gpc_master_model
(
    input wire logic clk_i,
    output logic pipe_req_n_o,
    output logic sba_cmd_o,
    output logic sync_req_o
);
    // Only rate the card supports, read before programming
    localparam logic [2:0] CAP = 3'h1;
    // Idle pin levels
    initial
    begin
        pipe_req_n_o = 1'b1;
        sba_cmd_o = 1'b0;
        sync_req_o = 1'b0;
    end
    // Request pin held len cycles: 0 pipe, 1 sideband, 2 sync
    task req(input int sel, input int len);
        @(posedge clk_i);
        if (sel == 0)
            pipe_req_n_o <= 1'b0;
        else if (sel == 1)
            sba_cmd_o <= 1'b1;
        else
            sync_req_o <= 1'b1;
        repeat (len) @(posedge clk_i);
        pipe_req_n_o <= 1'b1;
        sba_cmd_o <= 1'b0;
        sync_req_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : req
endmodule : gpc_master_model

/* tb/tb.sv */
// Bench for the graphics port command register.
// Assumes the design, its package and the master model are compiled.
`timescale 1ns/100ps
module tb;
    logic CLK_I, SYS_RST_I, REG_WR_I, REG_RD_I, SERVICE_DONE_I;
    logic [7:0] REG_ADDR_I;
    logic [31:0] REG_WDATA_I, REG_RDATA_O;
    logic PIPE_REQ_N_I, SBA_CMD_I, SYNC_REQ_I, PIPE_ACCEPT_O, SBA_ISSUE_O;
    logic SYNC_ACCEPT_O, SERVICE_PEND_O, QUEUE_FULL_O, PORT_EN_O;
    logic SBA_EN_O, POSTED_WRITE_EN_O;
    logic [2:0] AD_RATE_O, SBA_RATE_O;
    wire [2:0] pulses = {SYNC_ACCEPT_O, SBA_ISSUE_O, PIPE_ACCEPT_O};
    int num_errors = 0;
    int compares = 0;
    localparam logic [7:0] CMD = gpc_pkg::CMD_OFFSET;
    localparam logic [7:0] AUX = gpc_pkg::AUX_OFFSET;
    // Rows: word written, word read back
    logic [31:0] row_w [4] = '{32'h0000_0301, 32'hFFFF_FFEA,
        32'h0000_0204, 32'h0000_0101};
    logic [31:0] row_r [4] = '{32'h0000_0301, 32'h0000_0302,
        32'h0000_0204, 32'h0000_0101};
    gpc_command_ctrl #(.QUEUE_DEPTH(2)) i_dut (
        .CLK_I, .SYS_RST_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I,
        .REG_RD_I, .REG_RDATA_O, .PIPE_REQ_N_I, .SBA_CMD_I, .SYNC_REQ_I,
        .SERVICE_DONE_I, .PIPE_ACCEPT_O, .SBA_ISSUE_O, .SYNC_ACCEPT_O,
        .SERVICE_PEND_O, .QUEUE_FULL_O, .PORT_EN_O, .SBA_EN_O,
        .POSTED_WRITE_EN_O, .AD_RATE_O, .SBA_RATE_O
    );
    gpc_master_model i_master (.clk_i(CLK_I), .pipe_req_n_o(PIPE_REQ_N_I),
        .sba_cmd_o(SBA_CMD_I), .sync_req_o(SYNC_REQ_I));
    task chk(input string name, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        REG_WR_I <= 1'b1;
        @(posedge CLK_I);
        REG_WR_I <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK_I);
        REG_ADDR_I <= a;
        REG_RD_I <= 1'b1;
        @(posedge CLK_I);
        REG_RD_I <= 1'b0;
        #1 chk("read data", e, REG_RDATA_O);
    endtask : rd
    // Look for one pulse of the chosen kind over a fixed span
    task watch(input int sel, input logic e);
        logic seen;
        seen = 1'b0;
        repeat (16) @(posedge CLK_I) #1 seen |= pulses[sel];
        chk($sformatf("pulse %0d", sel), {31'h0, e}, {31'h0, seen});
    endtask : watch
    task final_report;
        $display("Comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    // Clock
    initial
    begin
        CLK_I = 1'b0;
        forever #12.5 CLK_I = ~CLK_I;
    end
    // Watchdog
    initial
    begin
        repeat (3000) @(posedge CLK_I);
        num_errors++;
        final_report;
    end
    // Tests
    initial
    begin
        SYS_RST_I = 1'b1;
        REG_WR_I = 1'b0;
        REG_RD_I = 1'b0;
        SERVICE_DONE_I = 1'b0;
        REG_ADDR_I = '0;
        REG_WDATA_I = '0;
        repeat (8) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        rd(CMD, 32'h0000_0000);
        chk("outputs", 0, {PORT_EN_O, SBA_EN_O, AD_RATE_O});
        $display("reset test done");
        for (int i = 0; i < 4; i++)
        begin
            wr(CMD, row_w[i]);
            rd(CMD, row_r[i]);
            chk("enables", row_r[i][9:8], {SBA_EN_O, PORT_EN_O});
            chk("rate", row_r[i][2:0], AD_RATE_O);
            chk("side rate", row_r[i][2:0], SBA_RATE_O);
            chk("posted write", 0, POSTED_WRITE_EN_O);
        end
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        wr(CMD, 32'h0000_0304);
        wr(AUX, 32'hFFFF_FFFF);
        rd(AUX, 32'h0000_0001);
        chk("masked rate", 0, AD_RATE_O);
        wr(CMD, 32'h0000_0301);
        rd(CMD, 32'h0000_0305);
        wr(AUX, 32'h0000_0000);
        wr(CMD, 32'h0000_0301);
        wr(AUX, 32'h0000_0001);
        wr(CMD, 32'h0000_0304);
        rd(CMD, 32'h0000_0300);
        wr(AUX, 32'h0000_0000);
        wr(CMD, 32'h0000_0300 | i_master.CAP);
        #1 chk("rate match", i_master.CAP, AD_RATE_O);
        $display("register test done");
        fork i_master.req(0, 2); watch(0, 1); join
        wr(CMD, 32'h0000_0001);
        fork i_master.req(0, 6); watch(0, 0); join
        fork i_master.req(2, 2); watch(2, 0); join
        fork i_master.req(1, 3); watch(1, 0); join
        chk("pending", 1, SERVICE_PEND_O);
        @(posedge CLK_I);
        SERVICE_DONE_I <= 1'b1;
        @(posedge CLK_I);
        SERVICE_DONE_I <= 1'b0;
        #1 chk("drained", 0, SERVICE_PEND_O);
        $display("request test done");
        wr(CMD, 32'h0000_0101);
        fork i_master.req(1, 3); watch(1, 0); join
        fork i_master.req(2, 2); watch(2, 1); join
        wr(CMD, 32'h0000_0301);
        fork i_master.req(1, 3); watch(1, 1); join
        fork
            i_master.req(1, 8);
            begin
                repeat (3) @(posedge CLK_I);
                wr(CMD, 32'h0000_0001);
            end
            watch(1, 1);
        join
        $display("sideband test done");
        wr(CMD, 32'h0000_0101);
        fork i_master.req(0, 2); watch(0, 1); join
        fork i_master.req(0, 2); watch(0, 1); join
        chk("full", 1, QUEUE_FULL_O);
        fork i_master.req(0, 2); watch(0, 0); join
        $display("queue test done");
        // Reset in mid-run clears the queue and the command register
        @(posedge CLK_I);
        SYS_RST_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        #1 chk("reset queue", 0, {QUEUE_FULL_O, SERVICE_PEND_O});
        rd(CMD, 32'h0000_0000);
        $display("mid reset test done");
        final_report;
    end
endmodule : tb
